// >>> switch_route_map.svh
// Purpose: Register offsets, reset values, field positions and timing for the route config bank.
// Assumes: Byte-wide registers addressed by an 8-bit pointer.
// Notes: Definitions only.
`ifndef SWITCH_ROUTE_MAP_SVH
`define SWITCH_ROUTE_MAP_SVH

`define FAST_MODE_OFS 8'h00
`define SIDE_MODE_OFS 8'h01
`define RX_SET_OFS 8'h10
`define PULSE_LO_OFS 8'h11
`define PULSE_HI_OFS 8'h12

`define FAST_MODE_RST 8'h40
`define SIDE_MODE_RST 8'h40
`define RX_SET_RST 8'h01
`define PULSE_RST 8'h00

`define EN_BIT 6
`define MODE_MSB 5
`define MODE_LSB 4
`define SEL_MSB 3
`define TERM_BIT 0

`define BYTE_BITS 4'h8
`define TERM_PULSE_MS 100
`define SYS_CLK_KHZ 25000
`define PULSE_CNT_W 22

`endif

// >>> switch_route_pkg.sv
// Purpose: Types shared by the route config bank.
// Assumes: Nothing beyond the map header.
// Notes: Mode code 2'b11 is never held in a mode register.
package switch_route_pkg;
  typedef enum logic [1:0] {
    MODE_QUAD = 2'b00,
    MODE_DUAL = 2'b01,
    MODE_SINGLE = 2'b10,
    MODE_ILLEGAL = 2'b11
  } sw_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_ADDR_ACK = 4'b0010,
    ST_PTR = 4'b0011,
    ST_PTR_ACK = 4'b0100,
    ST_WR = 4'b0101,
    ST_WR_ACK = 4'b0110,
    ST_RD = 4'b0111,
    ST_RD_ACK = 4'b1000
  } bus_state_t;
endpackage : switch_route_pkg

// >>> switch_route_config_regs.sv
// Purpose: Two-wire serial register bank that steers a four-source crossbar and its terminations.
// Assumes: scl and sda_in are synchronous to sys_clk and much slower than it.
// Notes: Channel indices are flat, A0 = 0 up to D3 = 15; route outputs hold four 4-bit indices.
// Operation
// - Fast enable 0 gives standby, 1 runs
// - Fast mode codes pick quad, dual, single
// - Fast mode code 11 keeps previous mode
// - Quad: low two bits pick whole source
// - Dual: three bits pick channel pair
// - Single: four bits pick one channel
// - Side enable 0 disconnects all common lines
// - Side mode code 11 keeps previous mode
// - Side quad: low bits pick whole source
// - Side dual: pair A/C or B/D lines
// - Side single: four bits pick one line
// - Termination bit disconnects or connects inputs
// - Pulsed channel loses termination on switch
// - Serial access locks out strap inputs until reset
`timescale 1ns/10ps
`include "switch_route_map.svh"
module switch_route_config_regs #(
  parameter logic [3:0] DEV_ADDR_HI = 4'hA,
  parameter int unsigned PULSE_CYCLES = `TERM_PULSE_MS * `SYS_CLK_KHZ
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [2:0] addr_strap,
  input wire logic pp_enable,
  input wire logic [1:0] pp_source,
  output logic fast_path_enable,
  output logic fast_standby,
  output switch_route_pkg::sw_mode_t fast_mode,
  output logic [15:0] fast_route,
  output logic side_path_enable,
  output switch_route_pkg::sw_mode_t side_mode,
  output logic [15:0] side_common_lines,
  output logic [15:0] input_termination_on
);
  import switch_route_pkg::*;
  localparam logic [7:0] FAST_RST = `FAST_MODE_RST;
  localparam logic [7:0] SIDE_RST = `SIDE_MODE_RST;
  localparam logic [7:0] RX_RST = `RX_SET_RST;
  localparam logic [`PULSE_CNT_W-1:0] PULSE_LOAD = `PULSE_CNT_W'(PULSE_CYCLES);
  bus_state_t state_r;
  logic scl_r, sda_r, rw_r, sda_oe_r, serial_used_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r, ptr_r, rd_byte;
  logic fast_en_r, side_en_r, term_on_r;
  sw_mode_t fast_mode_r, side_mode_r;
  logic [3:0] fast_sel_r, side_sel_r;
  logic [15:0] pulse_sel_r, pulse_by_ch, fast_route_nxt, fast_route_r, side_route_r;
  logic [15:0] term_r;
  logic side_en_out_r;
  logic [`PULSE_CNT_W-1:0] pulse_cnt_r;
  logic scl_rise, scl_fall, bus_start, bus_stop, byte_done, addr_hit, wr_stb;
  // Flat channel index for one output or common line in the given mode.
  function automatic logic [3:0] route_idx(input sw_mode_t m, input logic [3:0] sel,
                                           input logic [1:0] k, input logic aux);
    case (m)
      MODE_QUAD: route_idx = {sel[1:0], k};
      MODE_DUAL: route_idx = aux ? {k[1], sel[2:0]} : {sel[2:0], k[1]};
      default: route_idx = sel;
    endcase
  endfunction : route_idx
  function automatic logic [7:0] read_byte(input logic [7:0] p);
    case (p)
      `FAST_MODE_OFS: read_byte = {1'b0, fast_en_r, fast_mode_r, fast_sel_r};
      `SIDE_MODE_OFS: read_byte = {1'b0, side_en_r, side_mode_r, side_sel_r};
      `RX_SET_OFS: read_byte = {7'h00, term_on_r};
      `PULSE_LO_OFS: read_byte = pulse_sel_r[7:0];
      `PULSE_HI_OFS: read_byte = pulse_sel_r[15:8];
      default: read_byte = 8'h00;
    endcase
  endfunction : read_byte
  always_comb rd_byte = read_byte(ptr_r);
  assign scl_rise = !scl_r && scl;
  assign scl_fall = scl_r && !scl;
  assign bus_start = scl_r && scl && sda_r && !sda_in;
  assign bus_stop = scl_r && scl && !sda_r && sda_in;
  assign byte_done = scl_fall && (bit_cnt_r == `BYTE_BITS);
  assign addr_hit = shift_r[7:1] == {DEV_ADDR_HI, addr_strap};
  assign wr_stb = byte_done && (state_r == ST_WR);
  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_r;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      scl_r <= scl;
      sda_r <= sda_in;
    end
  end
  // Serial slave: bits are taken on scl rise and driven after scl fall.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (bus_start) begin
      state_r <= ST_ADDR;
      bit_cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (bus_stop) begin
      state_r <= ST_IDLE;
      sda_oe_r <= 1'b0;
    end else if (scl_rise) begin
      case (state_r)
        ST_ADDR, ST_PTR, ST_WR: begin
          shift_r <= {shift_r[6:0], sda_in};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
        ST_RD: bit_cnt_r <= bit_cnt_r + 4'h1;
        ST_RD_ACK: if (sda_in) state_r <= ST_IDLE;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state_r)
        ST_ADDR: if (byte_done) begin
          state_r <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
          sda_oe_r <= addr_hit;
          rw_r <= shift_r[0];
          bit_cnt_r <= 4'h0;
        end
        ST_ADDR_ACK, ST_RD_ACK: begin
          bit_cnt_r <= 4'h0;
          if (rw_r) begin
            state_r <= ST_RD;
            shift_r <= rd_byte;
            sda_oe_r <= !rd_byte[7];
          end else begin
            state_r <= ST_PTR;
            sda_oe_r <= 1'b0;
          end
        end
        ST_PTR: if (byte_done) begin
          ptr_r <= shift_r;
          state_r <= ST_PTR_ACK;
          sda_oe_r <= 1'b1;
        end
        ST_WR: if (byte_done) begin
          ptr_r <= ptr_r + 8'h01;
          state_r <= ST_WR_ACK;
          sda_oe_r <= 1'b1;
        end
        ST_PTR_ACK, ST_WR_ACK: begin
          state_r <= ST_WR;
          bit_cnt_r <= 4'h0;
          sda_oe_r <= 1'b0;
        end
        ST_RD: if (byte_done) begin
          ptr_r <= ptr_r + 8'h01;
          state_r <= ST_RD_ACK;
          sda_oe_r <= 1'b0;
        end else begin
          sda_oe_r <= !shift_r[6];
          shift_r <= {shift_r[6:0], 1'b0};
        end
        default: ;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) serial_used_r <= 1'b0;
    else if (byte_done && state_r == ST_ADDR && addr_hit) serial_used_r <= 1'b1;
  end
  // Until the bus is used the straps steer the bank; afterwards only writes do.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fast_en_r <= FAST_RST[`EN_BIT];
      fast_mode_r <= sw_mode_t'(FAST_RST[`MODE_MSB:`MODE_LSB]);
      fast_sel_r <= FAST_RST[`SEL_MSB:0];
      side_en_r <= SIDE_RST[`EN_BIT];
      side_mode_r <= sw_mode_t'(SIDE_RST[`MODE_MSB:`MODE_LSB]);
      side_sel_r <= SIDE_RST[`SEL_MSB:0];
      term_on_r <= RX_RST[`TERM_BIT];
      pulse_sel_r <= {`PULSE_RST, `PULSE_RST};
    end else if (!serial_used_r) begin
      fast_en_r <= pp_enable;
      fast_mode_r <= MODE_QUAD;
      fast_sel_r <= {2'b00, pp_source};
      side_en_r <= 1'b1;
      side_mode_r <= MODE_QUAD;
      side_sel_r <= {2'b00, pp_source};
      term_on_r <= 1'b1;
    end else if (wr_stb) begin
      case (ptr_r)
        `FAST_MODE_OFS: begin
          fast_en_r <= shift_r[`EN_BIT];
          fast_sel_r <= shift_r[`SEL_MSB:0];
          if (shift_r[`MODE_MSB:`MODE_LSB] != MODE_ILLEGAL)
            fast_mode_r <= sw_mode_t'(shift_r[`MODE_MSB:`MODE_LSB]);
        end
        `SIDE_MODE_OFS: begin
          side_en_r <= shift_r[`EN_BIT];
          side_sel_r <= shift_r[`SEL_MSB:0];
          if (shift_r[`MODE_MSB:`MODE_LSB] != MODE_ILLEGAL)
            side_mode_r <= sw_mode_t'(shift_r[`MODE_MSB:`MODE_LSB]);
        end
        `RX_SET_OFS: term_on_r <= shift_r[`TERM_BIT];
        `PULSE_LO_OFS: pulse_sel_r[7:0] <= shift_r;
        `PULSE_HI_OFS: pulse_sel_r[15:8] <= shift_r;
        default: ;
      endcase
    end
  end
  always_comb begin
    fast_route_nxt = 16'h0000;
    pulse_by_ch = 16'h0000;
    for (int k = 0; k < 4; k++) begin
      fast_route_nxt[k*4 +: 4] = route_idx(fast_mode_r, fast_sel_r, 2'(k), 1'b0);
      pulse_by_ch[k] = pulse_sel_r[k + 4];
      pulse_by_ch[k + 4] = pulse_sel_r[k];
      pulse_by_ch[k + 8] = pulse_sel_r[11 - k];
      pulse_by_ch[k + 12] = pulse_sel_r[15 - k];
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fast_route_r <= 16'h0000;
      side_route_r <= 16'h0000;
      side_en_out_r <= 1'b0;
    end else begin
      fast_route_r <= fast_route_nxt;
      side_en_out_r <= side_en_r;
      for (int k = 0; k < 4; k++)
        side_route_r[k*4 +: 4] <= route_idx(side_mode_r, side_sel_r, 2'(k), 1'b1);
    end
  end
  // A source change restarts one shared disconnect window for every pulsed channel.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) pulse_cnt_r <= '0;
    else if (fast_route_nxt != fast_route_r) pulse_cnt_r <= PULSE_LOAD;
    else if (pulse_cnt_r != '0) pulse_cnt_r <= pulse_cnt_r - `PULSE_CNT_W'(1);
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) term_r <= 16'h0000;
    else term_r <= {16{term_on_r}} & ~({16{pulse_cnt_r != '0}} & pulse_by_ch);
  end
  assign fast_path_enable = fast_en_r;
  assign fast_standby = !fast_en_r;
  assign fast_mode = fast_mode_r;
  assign fast_route = fast_route_r;
  assign side_path_enable = side_en_out_r;
  assign side_mode = side_mode_r;
  assign side_common_lines = side_route_r;
  assign input_termination_on = term_r;
  a_fast_illegal_kept: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_stb && ptr_r == `FAST_MODE_OFS && shift_r[`MODE_MSB:`MODE_LSB] == 2'b11
    |=> $stable(fast_mode_r)) else $error("fast mode changed on illegal code");
  a_side_illegal_kept: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_stb && ptr_r == `SIDE_MODE_OFS && shift_r[`MODE_MSB:`MODE_LSB] == 2'b11
    |=> $stable(side_mode_r)) else $error("side mode changed on illegal code");
  a_fast_enable_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_stb && serial_used_r && ptr_r == `FAST_MODE_OFS
    |=> fast_standby == !$past(shift_r[`EN_BIT])) else $error("standby not from write");
  a_quad_route: assert property (@(posedge sys_clk) disable iff (!rstn)
    fast_mode_r == MODE_QUAD |=> fast_route_r[11:8] == {$past(fast_sel_r[1:0]), 2'b10})
    else $error("quad route wrong");
  a_dual_route: assert property (@(posedge sys_clk) disable iff (!rstn)
    fast_mode_r == MODE_DUAL |=> fast_route_r[15:12] == {$past(fast_sel_r[2:0]), 1'b1}
    && fast_route_r[3:0] == {$past(fast_sel_r[2:0]), 1'b0}) else $error("dual route wrong");
  a_single_route: assert property (@(posedge sys_clk) disable iff (!rstn)
    fast_mode_r == MODE_SINGLE
    |=> fast_route_r == {4{$past(fast_sel_r)}}) else $error("single route wrong");
  a_side_dual_route: assert property (@(posedge sys_clk) disable iff (!rstn)
    side_mode_r == MODE_DUAL |=> side_route_r[15:12] == {1'b1, $past(side_sel_r[2:0])}
    && side_route_r[3:0] == {1'b0, $past(side_sel_r[2:0])}) else $error("side dual route wrong");
  a_term_off: assert property (@(posedge sys_clk) disable iff (!rstn)
    !term_on_r |=> input_termination_on == 16'h0000) else $error("termination not off");
  a_pulse_window: assert property (@(posedge sys_clk) disable iff (!rstn)
    fast_route_nxt != fast_route_r && pulse_by_ch[0] && term_on_r && $stable(pulse_by_ch)
    |-> ##2 !input_termination_on[0]) else $error("pulsed channel not disconnected");
  a_serial_lock: assert property (@(posedge sys_clk) disable iff (!rstn)
    serial_used_r && !wr_stb |=> $stable(fast_sel_r) && serial_used_r)
    else $error("strap or idle changed bank after serial access");
  c_write_done: cover property (@(posedge sys_clk) disable iff (!rstn) wr_stb);
  c_read_byte: cover property (@(posedge sys_clk) disable iff (!rstn)
    state_r == ST_RD_ACK && scl_fall);
  c_single_mode: cover property (@(posedge sys_clk) disable iff (!rstn)
    fast_mode_r == MODE_SINGLE && side_mode_r == MODE_DUAL);
  c_pulse_end: cover property (@(posedge sys_clk) disable iff (!rstn)
    pulse_cnt_r == `PULSE_CNT_W'(1));
endmodule : switch_route_config_regs

// >>> two_wire_host.sv
// Purpose: Host model that masters the two-wire serial configuration bus.
// Assumes: Pull-up on the data line; the clock is high for six sys_clk cycles and low for seven.
// Notes: Changes its lines only just after a rising sys_clk edge.
`timescale 1ns/10ps
module two_wire_host (
  input wire logic sys_clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda_in
);
  logic pull_low_r = 1'b0;
  initial scl = 1'b1;
  // Open-drain wire with a pull-up: low while either side pulls it.
  assign sda_in = ~(pull_low_r | sda_oe);
  task automatic half;
    repeat (6) @(posedge sys_clk);
  endtask : half
  task automatic clk_bit(input logic b, output logic seen);
    @(posedge sys_clk);
    pull_low_r <= ~b;
    half();
    scl <= 1'b1;
    half();
    seen = sda_in;
    scl <= 1'b0;
  endtask : clk_bit
  // Data is released before the clock rises, so a repeated start is never seen as a stop.
  task automatic start_cond;
    @(posedge sys_clk);
    pull_low_r <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    pull_low_r <= 1'b1;
    half();
    scl <= 1'b0;
  endtask : start_cond
  task automatic stop_cond;
    @(posedge sys_clk);
    pull_low_r <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    pull_low_r <= 1'b0;
    half();
  endtask : stop_cond
  task automatic xfer(input logic [7:0] tx, input logic nine, output logic [7:0] rx,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(tx[i], s);
      rx[i] = s;
    end
    clk_bit(nine, s);
    ack = ~s;
  endtask : xfer
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] val,
                           output logic ok);
    logic [7:0] rx;
    logic a1, a2, a3;
    start_cond();
    xfer({dev, 1'b0}, 1'b1, rx, a1);
    xfer(ptr, 1'b1, rx, a2);
    xfer(val, 1'b1, rx, a3);
    stop_cond();
    ok = a1 & a2 & a3;
  endtask : write_reg
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] val);
    logic [7:0] rx;
    logic a;
    start_cond();
    xfer({dev, 1'b0}, 1'b1, rx, a);
    xfer(ptr, 1'b1, rx, a);
    start_cond();
    xfer({dev, 1'b1}, 1'b1, rx, a);
    xfer(8'hFF, 1'b1, val, a);
    stop_cond();
  endtask : read_reg
endmodule : two_wire_host

// >>> tb.sv
// Purpose: Self-checking bench for the route config bank.
// Assumes: Host model masters the serial bus; termination window shortened.
// Notes: Each scenario task drives the bank and judges it before returning.
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin n_errors++; \
  $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
module tb;
  import switch_route_pkg::*;
  localparam int PW = 20;
  localparam logic [6:0] DEV = 7'h52;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic pp_enable = 1'b0;
  logic [1:0] pp_source = 2'h2;
  logic scl, sda_in, sda_out, sda_oe, fast_path_enable, fast_standby, side_path_enable;
  sw_mode_t fast_mode, side_mode;
  logic [15:0] fast_route, side_common_lines, input_termination_on;
  int n_errors = 0;
  int total_checks = 0;
  logic ok;
  logic [7:0] rd;
  always #20 sys_clk = ~sys_clk;
  two_wire_host host (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl(scl), .sda_in(sda_in));
  switch_route_config_regs #(.DEV_ADDR_HI(4'hA), .PULSE_CYCLES(PW)) dut (.sys_clk(sys_clk),
    .rstn(rstn), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap(3'h2), .pp_enable(pp_enable), .pp_source(pp_source),
    .fast_path_enable(fast_path_enable), .fast_standby(fast_standby), .fast_mode(fast_mode),
    .fast_route(fast_route), .side_path_enable(side_path_enable), .side_mode(side_mode),
    .side_common_lines(side_common_lines), .input_termination_on(input_termination_on));
  function automatic logic [15:0] route_exp(input logic [1:0] m, input logic [3:0] s,
                                            input logic side);
    logic [15:0] r;
    for (int k = 0; k < 4; k++) begin
      case (m)
        2'h0: r[4*k +: 4] = {s[1:0], 2'(k)};
        2'h1: r[4*k +: 4] = side ? {k[1], s[2:0]} : {s[2:0], k[1]};
        default: r[4*k +: 4] = s;
      endcase
    end
    return r;
  endfunction : route_exp
  task automatic complete_run;
    if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic check_straps;
    repeat (3) @(posedge sys_clk);
    `CHK("fast_standby", 1'b1, fast_standby)
    `CHK("strap_route", route_exp(2'h0, 4'h2, 1'b0), fast_route)
    `CHK("strap_side", route_exp(2'h0, 4'h2, 1'b1), side_common_lines)
    `CHK("strap_term", 16'hFFFF, input_termination_on)
    `CHK("sda_out", 1'b0, sda_out)
    host.write_reg(DEV, 8'h00, 8'h41, ok);
    pp_source <= 2'h3;
    repeat (4) @(posedge sys_clk);
    `CHK("lockout", route_exp(2'h0, 4'h1, 1'b0), fast_route)
  endtask : check_straps
  task automatic check_modes(input logic [7:0] ofs, input logic side);
    logic [7:0] vals [5] = '{8'h4D, 8'h5B, 8'h6F, 8'h7A, 8'h00};
    logic [1:0] m;
    logic [1:0] prv = 2'h0;
    foreach (vals[i]) begin
      host.write_reg(DEV, ofs, vals[i], ok);
      m = (vals[i][5:4] == 2'h3) ? prv : vals[i][5:4];
      prv = m;
      repeat (4) @(posedge sys_clk);
      `CHK("ack", 1'b1, ok)
      `CHK("mode", m, side ? side_mode : fast_mode)
      `CHK("route", route_exp(m, vals[i][3:0], side), side ? side_common_lines : fast_route)
      `CHK("enable", vals[i][6], side ? side_path_enable : fast_path_enable)
      if (!side) `CHK("standby", ~vals[i][6], fast_standby)
      host.read_reg(DEV, ofs, rd);
      `CHK("readback", {1'b0, vals[i][6], m, vals[i][3:0]}, rd)
    end
  endtask : check_modes
  task automatic check_refusals;
    logic [15:0] keep;
    keep = fast_route;
    host.write_reg(DEV ^ 7'h01, 8'h00, 8'h6F, ok);
    `CHK("no_ack", 1'b0, ok)
    `CHK("kept_route", keep, fast_route)
    host.read_reg(DEV, 8'h05, rd);
    `CHK("unmapped", 8'h00, rd)
  endtask : check_refusals
  task automatic check_termination;
    int n;
    host.write_reg(DEV, 8'h10, 8'h00, ok);
    `CHK("term_off", 16'h0000, input_termination_on)
    host.write_reg(DEV, 8'h10, 8'h01, ok);
    `CHK("term_on", 16'hFFFF, input_termination_on)
    host.write_reg(DEV, 8'h11, 8'h10, ok);
    host.write_reg(DEV, 8'h12, 8'h01, ok);
    host.read_reg(DEV, 8'h11, rd);
    `CHK("pulse_readback", 8'h10, rd)
    n = 0;
    fork
      host.write_reg(DEV, 8'h00, 8'h42, ok);
      begin
        for (int i = 0; i < 400 && input_termination_on[0] !== 1'b0; i++) @(posedge sys_clk);
        if (input_termination_on[0] !== 1'b0) begin
          n_errors++;
          complete_run();
        end
        #1;
        `CHK("pulse_mask", 16'hF7FE, input_termination_on)
        while (input_termination_on[0] === 1'b0 && n < 100) begin
          @(posedge sys_clk);
          #1;
          n++;
        end
        if (n == 100) begin
          n_errors++;
          complete_run();
        end
      end
    join
    `CHK("pulse_len", 1'b1, n >= PW - 1 && n <= PW + 1)
  endtask : check_termination
  initial begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    check_straps();
    check_modes(8'h00, 1'b0);
    check_modes(8'h01, 1'b1);
    check_refusals();
    check_termination();
    complete_run();
  end
endmodule : tb
